// ===== hdl/supply_fault_reset_monitor.sv
// supply supervision, reset generation and measurement gating
//
// What this block and its controller do
// [R1] main over flagged after filter time elapses
// [R2] unmasked main over flag raises alarm
// [R3] main over only flags, never resets
// [R4] main over clear needs condition gone
// [R5] enabled main low sets flag, guarded clear
// [R6] comm regulator under flags, then retries
// [R7] comm regulator over sets its flag
// [R8] controller clears comm faults after link resumes
// [R9] analog regulator under flags, then retries
// [R10] analog over checked during conversion sequences
// [R11] main under holds reset, then power-on
// [R12] logic supply loss forces power-on reset
// [R13] power-on reloads registers, flags, alarm
// [R14] reset pin acts only past filter
// [R15] soft reset bit write resets device
// [R16] pin or soft reset flags, alarm
// [R17] controller waits ready time before config
// [R18] on-demand start only normal or diagnostic
// [R19] cyclic timer triggers each sequence itself
// [R20] cyclic runs normal/sleep, timer nonzero
// [R21] current runs continuous, sleep follows timer
// [R22] coulomb frozen after sleep until acknowledged
// [R23] cyclic off after reset until written
// [R24] alarm is OR of enabled flags
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`include "supply_monitor_defs.svh"

module supply_fault_reset_monitor
  import supply_monitor_pkg::*;
#(
  parameter int RESET_FILTER_CYCLES = (`RESET_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int RETRY_CYCLES        = (`RETRY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int CYCLIC_BASE_CYCLES  = `CYCLIC_BASE_TIME_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // comparator and reset pins, asynchronous
  input  wire logic        main_supply_over_cmp,
  input  wire logic        main_supply_low_cmp,
  input  wire logic        main_supply_under_cmp,
  input  wire logic        logic_supply_low_cmp,
  input  wire logic        comm_regulator_under_cmp,
  input  wire logic        comm_regulator_over_cmp,
  input  wire logic        analog_regulator_under_cmp,
  input  wire logic        analog_regulator_over_cmp,
  input  wire logic        reset_pin,
  // operating context, same clock
  input  wire op_mode_type op_mode,
  input  wire logic        sequence_busy,
  // outputs
  output logic             alarm_pin,
  output logic             device_reset,
  output logic             comm_regulator_enable,
  output logic             analog_regulator_enable,
  output logic             measure_start,
  output logic             cyclic_trigger,
  output logic             current_measure_run,
  output logic             current_sample,
  output logic             coulomb_count_run,
  output logic             coulomb_clear
);

  localparam logic [31:0] FILTER_CNT = 32'(`MAIN_FILTER_CYCLES);
  localparam logic [31:0] RST_CNT    = 32'(RESET_FILTER_CYCLES);
  localparam logic [31:0] RETRY_CNT  = 32'(RETRY_CYCLES);
  localparam logic [31:0] CYC_BASE   = 32'(CYCLIC_BASE_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, change accepted when stages two and three agree

  wire  logic [`PIN_COUNT-1:0] pin_raw;
  logic [`PIN_COUNT-1:0]       sync1_r;
  logic [`PIN_COUNT-1:0]       sync2_r;
  logic [`PIN_COUNT-1:0]       sync3_r;
  logic [`PIN_COUNT-1:0]       pin_r;

  assign pin_raw = {reset_pin, analog_regulator_over_cmp, analog_regulator_under_cmp,
                    comm_regulator_over_cmp, comm_regulator_under_cmp, logic_supply_low_cmp,
                    main_supply_under_cmp, main_supply_low_cmp, main_supply_over_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          sync3_r[gi] <= 1'b0;
          pin_r[gi]   <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          sync3_r[gi] <= sync2_r[gi];
          if (sync2_r[gi] == sync3_r[gi]) begin
            pin_r[gi] <= sync3_r[gi];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, read data registered

  logic        ack_r;
  logic [31:0] readdata_r;
  logic [7:0]  cfg_r;
  logic [3:0]  st1_r;
  logic [3:0]  st2_r;
  logic [7:0]  enable_r;
  logic [1:0]  reg_on;
  logic [31:0] rd_mux;

  wire logic req      = avs_read | avs_write;
  wire logic wr_fire  = avs_write & ack_r & avs_byteenable[0];
  wire logic wr_cfg   = wr_fire & (avs_address == `REG_SYS_CFG);
  wire logic wr_st1   = wr_fire & (avs_address == `REG_STATUS1);
  wire logic wr_st2   = wr_fire & (avs_address == `REG_STATUS2);
  wire logic wr_en    = wr_fire & (avs_address == `REG_ENABLE);
  wire logic wr_cmd   = wr_fire & (avs_address == `REG_COMMAND);
  wire logic [7:0] wd = avs_writedata[7:0];

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata    = readdata_r;

  // unmapped addresses read zero and ignore writes
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      `REG_SYS_CFG: rd_mux = {24'h0, cfg_r};
      `REG_STATUS1: rd_mux = {28'h0, st1_r};
      `REG_STATUS2: rd_mux = {28'h0, st2_r};
      `REG_ENABLE:  rd_mux = {24'h0, enable_r};
      `REG_LIVE:    rd_mux = {21'h0, reg_on, pin_r};
      default:      rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_r      <= 1'b0;
      readdata_r <= 32'h0;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r) begin
        readdata_r <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  logic [31:0] pin_cnt_r;
  logic        pin_fired_r;
  logic        soft_r;

  wire logic por_hold  = pin_r[`PIN_MAIN_UNDER] | pin_r[`PIN_LOGIC_LOW];   // [R11] [R12]
  wire logic pin_evt   = pin_r[`PIN_RESET] & ~pin_fired_r & (pin_cnt_r >= RST_CNT); // [R14]
  wire logic soft_evt  = wr_cfg & wd[`CFG_SOFT_RST];                          // [R15]
  wire logic reinit    = por_hold | pin_evt | pin_fired_r | soft_r;
  wire logic main_over = pin_r[`PIN_MAIN_OVER];                               // [R3]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_cnt_r   <= 32'h0;
      pin_fired_r <= 1'b0;
      soft_r      <= 1'b0;
    end else begin
      pin_cnt_r   <= pin_r[`PIN_RESET] ? pin_cnt_r + ((pin_cnt_r >= RST_CNT) ? 32'h0 : 32'h1) : 32'h0;
      pin_fired_r <= pin_r[`PIN_RESET] & (pin_fired_r | pin_evt);
      soft_r      <= soft_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main supply filters

  logic [31:0] over_cnt_r;
  logic [31:0] low_cnt_r;

  wire logic over_hit = main_over & (over_cnt_r >= FILTER_CNT);                // [R1]
  wire logic low_hit  = pin_r[`PIN_MAIN_LOW] & (low_cnt_r >= FILTER_CNT)
                        & enable_r[`ST1_MAIN_LOW];                             // [R5]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      over_cnt_r <= 32'h0;
      low_cnt_r  <= 32'h0;
    end else begin
      over_cnt_r <= main_over ? over_cnt_r + ((over_cnt_r >= FILTER_CNT) ? 32'h0 : 32'h1) : 32'h0;
      low_cnt_r  <= pin_r[`PIN_MAIN_LOW] ? low_cnt_r + ((low_cnt_r >= FILTER_CNT) ? 32'h0 : 32'h1) : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // regulator shutdown and retry, index 0 comm, 1 analog

  regulator_state_type reg_state_r [2];
  logic [31:0]         retry_cnt_r [2];
  logic [1:0]          under_evt;
  wire  logic [1:0]    under_in = {pin_r[`PIN_ANA_UNDER], pin_r[`PIN_COMM_UNDER]};

  generate
    for (gi = 0; gi < 2; gi++) begin : g_reg
      assign reg_on[gi]    = (reg_state_r[gi] == REG_ON);
      assign under_evt[gi] = reg_on[gi] & under_in[gi];                       // [R6] [R9]
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          reg_state_r[gi] <= REG_ON;
          retry_cnt_r[gi] <= 32'h0;
        end else begin
          unique case (reg_state_r[gi])
            REG_ON: begin
              retry_cnt_r[gi] <= 32'h0;
              if (under_in[gi]) begin
                reg_state_r[gi] <= REG_RETRY;
              end
            end
            REG_RETRY: begin
              retry_cnt_r[gi] <= retry_cnt_r[gi] + 32'h1;
              if (retry_cnt_r[gi] >= RETRY_CNT - 32'h1) begin
                reg_state_r[gi] <= REG_ON;
              end
            end
          endcase
        end
      end
    end
  endgenerate

  assign comm_regulator_enable   = reg_on[0];
  assign analog_regulator_enable = reg_on[1];

  ////////////////////////////////////////////////////////////////////////////
  // status flags: set wins over a same-cycle clear

  wire logic [3:0] st1_set = {low_hit, over_hit, pin_evt | soft_evt, 1'b0};  // [R16]
  wire logic [3:0] st1_gone = {~pin_r[`PIN_MAIN_LOW], ~main_over, 2'b11};     // [R4]
  wire logic [3:0] st1_clr = {4{wr_st1}} & ~wd[3:0] & st1_gone;
  wire logic [3:0] st2_set = {pin_r[`PIN_ANA_OVER] & sequence_busy,          // [R10]
                              under_evt[1],
                              pin_r[`PIN_COMM_OVER],                          // [R7]
                              under_evt[0]};
  wire logic [3:0] st2_clr = {4{wr_st2}} & ~wd[3:0];                           // [R8]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st1_r <= `ST1_RESET;
      st2_r <= `ST2_RESET;
    end else if (por_hold) begin
      st1_r <= `ST1_RESET;                                                    // [R13]
      st2_r <= `ST2_RESET;
    end else begin
      st1_r <= st1_set | (st1_r & ~st1_clr);
      st2_r <= st2_set | (st2_r & ~st2_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and enables, reloaded by every reset source

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r    <= `CFG_RESET;
      enable_r <= `ENABLE_RESET;
    end else if (reinit) begin
      cfg_r    <= `CFG_RESET;                                                 // [R13] [R23]
      enable_r <= `ENABLE_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_r <= wd & `CFG_WR_MASK;
      end
      if (wr_en) begin
        enable_r <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement gating

  logic [31:0] cyc_cnt_r;
  logic        freeze_r;
  op_mode_type mode_prev_r;

  wire logic [2:0]  cyc_code   = cfg_r[`CFG_CYC_MSB:`CFG_CYC_LSB];
  wire logic [31:0] cyc_period = 32'(cyc_code) * CYC_BASE;
  wire logic is_normal = (op_mode == MODE_NORMAL);
  wire logic is_diag   = (op_mode == MODE_DIAG);
  wire logic is_sleep  = (op_mode == MODE_SLEEP);
  wire logic cyc_run   = (cyc_code != 3'h0) & (is_normal | is_sleep);        // [R20]
  wire logic cyc_hit   = cyc_run & (cyc_cnt_r >= cyc_period - 32'h1);         // [R19]
  wire logic cur_en    = cfg_r[`CFG_CUR_EN];
  wire logic soc_ok    = wr_cmd & wd[`CMD_SOC] & (is_normal | is_diag);      // [R18]
  wire logic cc_ack    = wr_cmd & wd[`CMD_COULOMB_ACK];
  wire logic wake_norm = (mode_prev_r == MODE_SLEEP) & is_normal & cur_en;   // [R22]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cyc_cnt_r   <= 32'h0;
      freeze_r    <= 1'b0;
      mode_prev_r <= MODE_INIT;
    end else begin
      cyc_cnt_r   <= (cyc_run & ~cyc_hit & ~reinit) ? cyc_cnt_r + 32'h1 : 32'h0;
      freeze_r    <= ~reinit & (wake_norm | (freeze_r & ~cc_ack));           // [R22]
      mode_prev_r <= op_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic alarm_r;
  logic dev_rst_r;
  logic start_r;
  logic trig_r;
  logic cur_run_r;
  logic cur_smp_r;
  logic cc_run_r;
  logic cc_clr_r;

  // alarm rises with power-on and reset-event flags since enables reload to all ones
  wire logic alarm_nxt = |({st2_r, st1_r} & enable_r);                        // [R2] [R24] [R13] [R16]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_r   <= 1'b1;
      dev_rst_r <= 1'b1;
      start_r   <= 1'b0;
      trig_r    <= 1'b0;
      cur_run_r <= 1'b0;
      cur_smp_r <= 1'b0;
      cc_run_r  <= 1'b0;
      cc_clr_r  <= 1'b0;
    end else begin
      alarm_r   <= alarm_nxt;
      dev_rst_r <= reinit;                                                    // [R11] [R14] [R15]
      start_r   <= soc_ok & ~reinit;
      trig_r    <= cyc_hit & ~reinit;
      cur_run_r <= cur_en & (is_normal | is_diag);                           // [R21]
      cur_smp_r <= cur_en & is_sleep & cyc_hit;                               // [R21]
      cc_run_r  <= cur_en & (is_normal | is_diag) & ~freeze_r & ~wake_norm;
      cc_clr_r  <= cc_ack;
    end
  end

  assign alarm_pin           = alarm_r;
  assign device_reset        = dev_rst_r;
  assign measure_start       = start_r;
  assign cyclic_trigger      = trig_r;
  assign current_measure_run = cur_run_r;
  assign current_sample      = cur_smp_r;
  assign coulomb_count_run   = cc_run_r;
  assign coulomb_clear       = cc_clr_r;

endmodule

// ===== hdl/supply_monitor_defs.svh
// constants for the supply fault and reset monitor
`ifndef SUPPLY_MONITOR_DEFS_SVH
`define SUPPLY_MONITOR_DEFS_SVH

// register byte offsets
`define REG_SYS_CFG      5'h00
`define REG_STATUS1      5'h04
`define REG_STATUS2      5'h08
`define REG_ENABLE       5'h0c
`define REG_COMMAND      5'h10
`define REG_LIVE         5'h14

// first_system_config_reg fields
`define CFG_SOFT_RST     0
`define CFG_CUR_EN       1
`define CFG_CYC_LSB      2
`define CFG_CYC_MSB      4
`define CFG_RESET        8'h00
`define CFG_WR_MASK      8'h1e

// first_alarm_status_reg fields
`define ST1_POR          0
`define ST1_RST_EVT      1
`define ST1_MAIN_OVER    2
`define ST1_MAIN_LOW     3
`define ST1_RESET        4'h1

// second_alarm_status_reg fields
`define ST2_COMM_UNDER   0
`define ST2_COMM_OVER    1
`define ST2_ANA_UNDER    2
`define ST2_ANA_OVER     3
`define ST2_RESET        4'h0

// first_alarm_enable_reg: low nibble gates status1, high nibble status2
`define ENABLE_RESET     8'hff

// command register bits
`define CMD_SOC          0
`define CMD_COULOMB_ACK  1

// synchronised pin indices
`define PIN_MAIN_OVER    0
`define PIN_MAIN_LOW     1
`define PIN_MAIN_UNDER   2
`define PIN_LOGIC_LOW    3
`define PIN_COMM_UNDER   4
`define PIN_COMM_OVER    5
`define PIN_ANA_UNDER    6
`define PIN_ANA_OVER     7
`define PIN_RESET        8
`define PIN_COUNT        9

// timing
`define CLK_PERIOD_NS          5
`define MAIN_FILTER_TIME_NS    10000
`define MAIN_FILTER_CYCLES     ((`MAIN_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_FILTER_TIME_NS   100000
`define RETRY_TIME_NS          1000000
`define CYCLIC_BASE_TIME_NS    100000000

`endif

// ===== hdl/supply_monitor_pkg.sv
// types shared by the supply fault and reset monitor
package supply_monitor_pkg;

  typedef enum logic [2:0] {
    MODE_INIT   = 3'h0,
    MODE_NORMAL = 3'h1,
    MODE_DIAG   = 3'h2,
    MODE_SLEEP  = 3'h3,
    MODE_IDLE   = 3'h4
  } op_mode_type;

  typedef enum logic [1:0] {
    REG_ON    = 2'b01,
    REG_RETRY = 2'b10
  } regulator_state_type;

endpackage

// ===== tb/pack_controller_model.sv
// pack controller model: register bus master of the monitor
module pack_controller_model #(
  parameter int READY_CYCLES = 40
) (
  // clock
  input  wire logic        clk_sys,
  // register bus
  output logic      [4:0]  avs_address    = 5'h00,
  output logic             avs_read       = 1'b0,
  output logic             avs_write      = 1'b0,
  output logic      [31:0] avs_writedata  = 32'h0,
  output logic      [3:0]  avs_byteenable = 4'hf,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  // slave never answered
  output logic             bus_hang       = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // request held until waitrequest is seen low, released only after that edge
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    q = avs_readdata;
    if (n == 20) bus_hang <= 1'b1;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  // no configuration until the supply has settled after a reset
  task automatic settle;
    repeat (READY_CYCLES) @(posedge clk_sys);
  endtask
endmodule

// ===== tb/supply_monitor_properties.sv
// checker for the supply fault and reset monitor
`include "supply_monitor_defs.svh"
module supply_monitor_properties
  import supply_monitor_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // supply pins and context
  input wire logic        main_supply_under_cmp,
  input wire logic        logic_supply_low_cmp,
  input wire op_mode_type op_mode,
  // monitor outputs
  input wire logic        alarm_pin,
  input wire logic        device_reset,
  input wire logic        comm_regulator_enable,
  input wire logic        analog_regulator_enable,
  input wire logic        measure_start,
  input wire logic        cyclic_trigger,
  input wire logic        current_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  wire cfg_wr = avs_write && !avs_waitrequest && avs_address == `REG_SYS_CFG;
  // only power-up clears it: other resets reload late, a pulse may slip past them
  logic armed_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) armed_r <= 1'b0;
    else if (cfg_wr && avs_writedata[4:2] != 3'h0) armed_r <= 1'b1;
  end
  sequence s_req_start; $rose(avs_read || avs_write); endsequence
  sequence s_one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  ////////////////////////////////////////
  a_wait_one_cycle: assert property (s_req_start |-> s_one_wait)
    else $error("bus wait not one cycle");
  a_reset_state: assert property (disable iff (1'b0) rst |-> alarm_pin && device_reset)
    else $error("reset outputs wrong");
  a_alarm_fall: assert property ($fell(alarm_pin) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("alarm fell without write");
  a_soc_mode: assert property (measure_start |-> ($past(op_mode) == MODE_NORMAL || $past(op_mode) == MODE_DIAG) ##1 !measure_start)
    else $error("start in wrong mode");
  a_cyclic_mode: assert property (cyclic_trigger |-> $past(op_mode) == MODE_NORMAL || $past(op_mode) == MODE_SLEEP)
    else $error("cyclic in wrong mode");
  a_cyclic_armed: assert property (cyclic_trigger |-> armed_r)
    else $error("cyclic before period");
  a_soft_reset: assert property (cfg_wr && avs_writedata[`CFG_SOFT_RST] |-> ##[1:2] device_reset)
    else $error("soft reset missing");
  a_main_under: assert property (main_supply_under_cmp [*7] |-> device_reset)
    else $error("under not held in reset");
  a_logic_low: assert property (logic_supply_low_cmp [*7] |-> device_reset)
    else $error("logic low not reset");
  a_comm_retry: assert property ($fell(comm_regulator_enable) |=> !comm_regulator_enable [*8])
    else $error("comm retry short");
  a_ana_retry: assert property ($fell(analog_regulator_enable) |=> !analog_regulator_enable [*8])
    else $error("analog retry short");
  a_sample_sleep: assert property (current_sample |-> $past(op_mode) == MODE_SLEEP)
    else $error("sample outside sleep");
endmodule

bind supply_fault_reset_monitor supply_monitor_properties props (
  .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
  .main_supply_under_cmp, .logic_supply_low_cmp, .op_mode, .alarm_pin, .device_reset,
  .comm_regulator_enable, .analog_regulator_enable, .measure_start, .cyclic_trigger, .current_sample
);

// ===== tb/testbench.sv
// self-checking bench for the supply fault and reset monitor
`include "supply_monitor_defs.svh"
module testbench
  import supply_monitor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened reset filter, retry and cyclic base counts
  localparam int RF = 20;
  localparam int RT = 10;
  localparam int CB = 50;
  logic        clk_sys       = 1'b0;
  logic        rst           = 1'b0;
  logic [8:0]  cmp           = 9'h000;
  op_mode_type op_mode       = MODE_NORMAL;
  logic        sequence_busy = 1'b0;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest, bus_hang;
  logic        alarm_pin, device_reset, comm_regulator_enable, analog_regulator_enable, measure_start;
  logic        cyclic_trigger, current_measure_run, current_sample, coulomb_count_run, coulomb_clear;
  int          err_count = 0, samples_checked = 0;
  int          n_start = 0, n_cyc = 0, n_samp = 0, n_clr = 0, n_rst = 0;

  supply_fault_reset_monitor #(.RESET_FILTER_CYCLES(RF), .RETRY_CYCLES(RT), .CYCLIC_BASE_CYCLES(CB)) dut (
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .main_supply_over_cmp(cmp[`PIN_MAIN_OVER]), .main_supply_low_cmp(cmp[`PIN_MAIN_LOW]),
    .main_supply_under_cmp(cmp[`PIN_MAIN_UNDER]), .logic_supply_low_cmp(cmp[`PIN_LOGIC_LOW]),
    .comm_regulator_under_cmp(cmp[`PIN_COMM_UNDER]), .comm_regulator_over_cmp(cmp[`PIN_COMM_OVER]),
    .analog_regulator_under_cmp(cmp[`PIN_ANA_UNDER]), .analog_regulator_over_cmp(cmp[`PIN_ANA_OVER]),
    .reset_pin(cmp[`PIN_RESET]), .op_mode, .sequence_busy, .alarm_pin, .device_reset, .comm_regulator_enable,
    .analog_regulator_enable, .measure_start, .cyclic_trigger, .current_measure_run, .current_sample,
    .coulomb_count_run, .coulomb_clear);
  pack_controller_model pc (.clk_sys, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .avs_readdata, .bus_hang);

  always #2.5 clk_sys = ~clk_sys;
  // pulse outputs are counted here so no scenario misses a one-cycle pulse
  always @(posedge clk_sys) begin
    n_start += (measure_start === 1'b1);
    n_cyc += (cyclic_trigger === 1'b1);
    n_samp += (current_sample === 1'b1);
    n_clr += (coulomb_clear === 1'b1);
    n_rst += (device_reset === 1'b1);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    pc.rd(a, q);
    chk(q, e);
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge clk_sys);
    cmp[i] <= v;
  endtask
  function automatic logic reg_on(input int k);
    return k ? analog_regulator_enable : comm_regulator_enable;
  endfunction
  task automatic test_done;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    rd_chk(`REG_STATUS1, 32'h1);
    rd_chk(`REG_STATUS2, 32'h0);
    rd_chk(`REG_SYS_CFG, 32'h0);
    rd_chk(`REG_ENABLE, 32'hff);
    rd_chk(5'h18, 32'h0);
    chk(alarm_pin, 1'b1);
    pc.wr(`REG_STATUS1, 8'h00);
    cyc(3);
    chk(alarm_pin, 1'b0);
  endtask
  task automatic t_main;
    pin(`PIN_MAIN_OVER, 1'b1);
    cyc(`MAIN_FILTER_CYCLES - 50);
    chk(alarm_pin, 1'b0);
    cyc(100);
    chk(alarm_pin, 1'b1);
    chk(device_reset, 1'b0);
    pc.wr(`REG_ENABLE, 8'hfb);
    cyc(3);
    chk(alarm_pin, 1'b0);
    pc.wr(`REG_ENABLE, 8'hf7);
    pc.wr(`REG_STATUS1, 8'h00);
    rd_chk(`REG_STATUS1, 32'h4);
    pin(`PIN_MAIN_OVER, 1'b0);
    pin(`PIN_MAIN_LOW, 1'b1);
    cyc(`MAIN_FILTER_CYCLES + 50);
    pc.wr(`REG_STATUS1, 8'h00);
    rd_chk(`REG_STATUS1, 32'h0);
    pc.wr(`REG_ENABLE, 8'hff);
    cyc(`MAIN_FILTER_CYCLES + 50);
    pc.wr(`REG_STATUS1, 8'h00);
    rd_chk(`REG_STATUS1, 32'h8);
    pin(`PIN_MAIN_LOW, 1'b0);
    cyc(6);
    pc.wr(`REG_STATUS1, 8'h00);
    rd_chk(`REG_STATUS1, 32'h0);
  endtask
  task automatic t_regs;
    int i;
    for (int k = 0; k < 2; k++) begin
      pin(k ? `PIN_ANA_UNDER : `PIN_COMM_UNDER, 1'b1);
      for (i = 0; i < 20 && reg_on(k); i++) cyc(1);
      chk(reg_on(k), 1'b0);
      pin(k ? `PIN_ANA_UNDER : `PIN_COMM_UNDER, 1'b0);
      for (i = 0; i < 40 && !reg_on(k); i++) cyc(1);
      chk(i >= RT - 2 && i <= RT + 1, 1'b1);
    end
    rd_chk(`REG_STATUS2, 32'h5);
    pin(`PIN_COMM_OVER, 1'b1);
    pin(`PIN_ANA_OVER, 1'b1);
    cyc(8);
    rd_chk(`REG_STATUS2, 32'h7);
    sequence_busy <= 1'b1;
    cyc(4);
    rd_chk(`REG_STATUS2, 32'hf);
    sequence_busy <= 1'b0;
    cmp <= 9'h000;
    cyc(6);
    pc.wr(`REG_STATUS2, 8'h00);
    rd_chk(`REG_STATUS2, 32'h0);
  endtask
  task automatic t_resets;
    int k;
    pc.wr(`REG_SYS_CFG, 8'h02);
    pin(`PIN_RESET, 1'b1);
    cyc(RF - 5);
    pin(`PIN_RESET, 1'b0);
    cyc(8);
    chk(device_reset, 1'b0);
    pin(`PIN_RESET, 1'b1);
    cyc(RF + 12);
    chk(device_reset, 1'b1);
    pin(`PIN_RESET, 1'b0);
    pc.settle;
    rd_chk(`REG_STATUS1, 32'h2);
    rd_chk(`REG_SYS_CFG, 32'h0);
    chk(alarm_pin, 1'b1);
    pc.wr(`REG_STATUS1, 8'h00);
    k = n_rst;
    pc.wr(`REG_SYS_CFG, 8'h01);
    cyc(4);
    chk(n_rst > k, 1'b1);
    pc.settle;
    rd_chk(`REG_STATUS1, 32'h2);
    rd_chk(`REG_SYS_CFG, 32'h0);
    for (int j = 0; j < 2; j++) begin
      pc.wr(`REG_STATUS1, 8'h00);
      pin(j ? `PIN_LOGIC_LOW : `PIN_MAIN_UNDER, 1'b1);
      cyc(8);
      chk(device_reset, 1'b1);
      pin(j ? `PIN_LOGIC_LOW : `PIN_MAIN_UNDER, 1'b0);
      pc.settle;
      rd_chk(`REG_STATUS1, 32'h1);
    end
  endtask
  task automatic t_measure;
    int k, j, d;
    for (int m = 0; m < 5; m++) begin
      op_mode <= op_mode_type'(m);
      k = n_start;
      pc.wr(`REG_COMMAND, 8'h01);
      cyc(3);
      chk(n_start - k, m == 1 || m == 2);
    end
    op_mode <= MODE_NORMAL;
    k = n_cyc;
    cyc(4 * CB);
    chk(n_cyc - k, 0);
    pc.wr(`REG_SYS_CFG, 8'h06);
    for (int m = 0; m < 5; m++) begin
      op_mode <= op_mode_type'(m);
      cyc(2);
      k = n_cyc;
      j = n_samp;
      cyc(5 * CB);
      d = n_cyc - k;
      chk((m == 1 || m == 3) ? (d >= 4 && d <= 6) : (d == 0), 1'b1);
      if (m == 3) chk(n_samp - j >= 4, 1'b1);
    end
    op_mode <= MODE_SLEEP;
    cyc(2);
    op_mode <= MODE_NORMAL;
    cyc(3);
    chk(current_measure_run, 1'b1);
    chk(coulomb_count_run, 1'b0);
    k = n_clr;
    pc.wr(`REG_COMMAND, 8'h02);
    cyc(3);
    chk(coulomb_count_run, 1'b1);
    chk(n_clr - k, 1);
    op_mode <= MODE_IDLE;
    cyc(3);
    chk(current_measure_run, 1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    #1;
    rst = 1'b1;
    cyc(4);
    rst <= 1'b0;
    t_reset;
    t_main;
    t_regs;
    t_resets;
    t_measure;
    test_done;
  end
  initial begin
    #500000;
    err_count++;
    test_done;
  end
  always @(posedge bus_hang) begin
    err_count++;
    test_done;
  end
endmodule
